/* rtl/sctr_pkg.sv */
// How it works
// R1 - all clocks come from five sources
// R2 - root clock: PLL output or internal oscillator
// R3 - core clock capped at half PLL rate
// R4 - core clock divided from root clock
// R5 - system bus and fabric bus clocks divided
// R6 - three peripheral clocks divided from root
// R7 - dedicated peripheral: select, then divide
// R8 - sampler clock: fast/20 if stable, else internal
// R9 - error-control count clock is fast/20
// R10 - monitors get monitored, sampling, register clocks
// R11 - monitors flag frequency anomalies while enabled
// R12 - each external output picks four sources
// R13 - two quartz inputs, two external outputs; the code has only one crystal input (xtal)
// R14 - crystal frequency code, upper codes prohibited
// R15 - selectors switch without runt pulses
`default_nettype none
package sctr_pkg;

  // ==========================================================
  // divider chain
  localparam int unsigned DIV_W = 10;
  localparam int unsigned DV_F20 = 0;
  localparam int unsigned DV_PLL = 1;
  localparam int unsigned DV_CPU = 2;
  localparam int unsigned DV_SBUS = 3;
  localparam int unsigned DV_FBUS = 4;
  localparam int unsigned DV_UHSB = 5;
  localparam int unsigned DV_HSB = 6;
  localparam int unsigned DV_LSB = 7;
  localparam int unsigned DV_PER = 8;
  localparam int unsigned DV_EXA = 9;
  localparam int unsigned DV_EXB = 10;
  localparam int unsigned DV_N = 11;

  localparam logic [DIV_W-1:0] RATIO_ONE = 10'h001;
  localparam logic [DIV_W-1:0] FAST_LPS_DIV = 10'h014; // fast oscillator / 20
  localparam logic [DIV_W-1:0] CORE_MIN_DIV = 10'h002; // vco runs at twice core max

  // ==========================================================
  // crystal frequency code
  localparam logic [2:0] XTAL_16MHZ = 3'h0;
  localparam logic [2:0] XTAL_20MHZ = 3'h1;
  localparam logic [2:0] XTAL_24MHZ = 3'h2;
  localparam logic [2:0] XTAL_40MHZ = 3'h3;
  localparam int unsigned XTAL_BAD_BIT = 2;

  // ==========================================================
  // clock monitor
  localparam int unsigned MON_N = 4;
  localparam int unsigned MON_CW = 16;
  localparam logic [MON_CW-1:0] MON_ONE = 16'h0001;
  localparam logic [MON_CW-1:0] MON_MAX = 16'hFFFF;
  localparam logic [7:0] GAP_ONE = 8'h01;

  // ==========================================================
  // selector codes
  typedef enum logic {ROOT_IOSC = 1'h0, ROOT_PLL = 1'h1} sctr_root_t;
  typedef enum logic {IOSC_SLOW = 1'h0, IOSC_FAST = 1'h1} sctr_iosc_t;
  typedef enum logic [1:0] {
    SEL_XTAL = 2'h0,
    SEL_FPER = 2'h1,
    SEL_SLOW = 2'h2,
    SEL_F20  = 2'h3
  } sctr_sel4_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic hv;
    logic pll;
    logic slow;
    logic fast;
    logic xtal;
  } sctr_src_t;

  typedef struct packed {
    logic [DIV_W-1:0] pll;
    logic [DIV_W-1:0] cpu;
    logic [DIV_W-1:0] sbus;
    logic [DIV_W-1:0] fbus;
    logic [DIV_W-1:0] uhsb;
    logic [DIV_W-1:0] hsb;
    logic [DIV_W-1:0] lsb;
    logic [DIV_W-1:0] per;
    logic [DIV_W-1:0] exa;
    logic [DIV_W-1:0] exb;
  } sctr_div_cfg_t;

  typedef struct packed {
    logic cpu;
    logic sbus;
    logic fbus;
    logic uhsb;
    logic hsb;
    logic lsb;
  } sctr_bus_tick_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             out;
  } sctr_div_st_t;

  typedef struct packed {
    sctr_src_t                       src_s1;
    sctr_src_t                       src_s2;
    sctr_src_t                       src_s3;
    logic                            stb_s1;
    logic                            stb_s2;
    sctr_root_t                      sys_sel;
    sctr_iosc_t                      iosc_sel;
    sctr_sel4_t                      per_sel;
    sctr_sel4_t                      exa_sel;
    sctr_sel4_t                      exb_sel;
    logic                            sys_tick;
    logic                            iosc_tick;
    logic                            lps_tick;
    logic                            ecm_tick;
    logic [MON_N-1:0]                mon_tick;
    logic                            smp_tick;
    logic                            reg_tick;
    logic                            xtal_err;
    logic [MON_CW-1:0]               win;
    logic [MON_N-1:0][MON_CW-1:0]    mon_cnt;
    logic [MON_N-1:0]                anom;
    logic [MON_N-1:0]                armed;
  } sctr_state_t;

endpackage
`default_nettype wire

/* rtl/sctr_tick_div.sv */
`timescale 1ns/10ps
`default_nettype none
module sctr_tick_div
  import sctr_pkg::*;
(
  // clock and reset
  input  wire logic             i_system_root_clock,
  input  wire logic             i_sys_rst,
  // enable in, ratio, enable out
  input  wire logic             i_tick,
  input  wire logic [DIV_W-1:0] i_ratio,
  output logic                  o_tick
);

  sctr_div_st_t st_ff;
  sctr_div_st_t nxt_st;
  logic [DIV_W-1:0] ratio_eff;

  // ratio zero behaves as one, so a cleared field never stalls the clock
  assign ratio_eff = (i_ratio == '0) ? RATIO_ONE : i_ratio;

  // ==========================================================
  // count input pulses, emit one pulse per ratio
  always_comb begin
    nxt_st = st_ff;
    nxt_st.out = 1'b0;
    if (i_tick) begin
      // >= rather than == so a lowered ratio takes effect at once
      if ((st_ff.cnt + RATIO_ONE) >= ratio_eff) begin
        nxt_st.cnt = '0;
        nxt_st.out = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + RATIO_ONE;
      end
    end
  end

  always_ff @(posedge i_system_root_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_tick = st_ff.out;

  // ==========================================================
  // an output pulse always follows an input pulse
  div_cause_a: assert property (@(posedge i_system_root_clock) disable iff (i_sys_rst) // R7
    o_tick |-> $past(i_tick))
    else $error("divider pulse without input pulse");

endmodule
`default_nettype wire

/* rtl/sctr_clock_tree.sv */
`timescale 1ns/10ps
`default_nettype none
module sctr_clock_tree
  import sctr_pkg::*;
#(
  parameter logic [MON_CW-1:0]            MON_WIN = 16'h0010,
  parameter logic [MON_N-1:0][MON_CW-1:0] MON_LO  = {MON_N{16'h0002}},
  parameter logic [MON_N-1:0][MON_CW-1:0] MON_HI  = {MON_N{16'h0100}}
)
(
  // clock and reset
  input  wire logic           i_system_root_clock,
  input  wire logic           i_sys_rst,
  // oscillator levels and fast oscillator stable, asynchronous
  input  wire sctr_src_t      i_src_lvl,
  input  wire logic           i_fast_stable,
  // selector and divider settings
  input  wire sctr_root_t     i_sys_sel,
  input  wire sctr_iosc_t     i_iosc_sel,
  input  wire sctr_sel4_t     i_per_sel,
  input  wire sctr_sel4_t     i_exa_sel,
  input  wire sctr_sel4_t     i_exb_sel,
  input  wire sctr_div_cfg_t  i_div_cfg,
  input  wire logic [2:0]     i_crystal_freq_select,
  input  wire logic [MON_N-1:0] i_mon_en,
  // root, internal and pll clock enables
  output logic                o_sys_tick,
  output logic                o_iosc_tick,
  output logic                o_pll_tick,
  // cpu, bus and peripheral clock enables
  output sctr_bus_tick_t      o_bus,
  output logic                o_per_tick,
  output logic                o_lps_tick,
  output logic                o_ecm_tick,
  // external clock outputs
  output logic                o_exa_tick,
  output logic                o_exb_tick,
  // clock monitor supply and result
  output logic [MON_N-1:0]    o_mon_tick,
  output logic                o_mon_smp_tick,
  output logic                o_mon_reg_tick,
  output logic [MON_N-1:0]    o_mon_anom,
  // crystal code prohibited
  output logic                o_xtal_cfg_err
);

  sctr_state_t st_ff;
  sctr_state_t nxt_st;
  sctr_src_t   src_tick;
  logic [DV_N-1:0]            dv_in;
  logic [DV_N-1:0]            dv_out;
  logic [DV_N-1:0][DIV_W-1:0] dv_ratio;
  logic iosc_cur;
  logic root_cur;
  logic per_cur;
  logic exa_cur;
  logic exb_cur;
  logic [DIV_W-1:0] cpu_ratio;
  logic win_end;
  logic [MON_N-1:0] mon_src;

  // ==========================================================
  // source pulses from the second sync stage against the third; limited to sources well below
  // half the system clock, faster ones must be pre-scaled at the oscillator
  assign src_tick = sctr_src_t'(st_ff.src_s2 & ~st_ff.src_s3); // R1 R13

  function automatic logic pick4(input sctr_sel4_t s, input logic xtal,
                                 input logic fper, input logic slow, input logic f20);
    unique case (s)
      SEL_XTAL: pick4 = xtal;
      SEL_FPER: pick4 = fper;
      SEL_SLOW: pick4 = slow;
      SEL_F20:  pick4 = f20;
    endcase
  endfunction

  // ==========================================================
  // selector outputs from the registered selections
  always_comb begin
    iosc_cur = (st_ff.iosc_sel == IOSC_FAST) ? src_tick.fast : src_tick.slow;
    root_cur = (st_ff.sys_sel == ROOT_PLL) ? dv_out[DV_PLL] : iosc_cur; // R2
    per_cur  = pick4(st_ff.per_sel, src_tick.xtal, dv_out[DV_HSB],
                     src_tick.slow, dv_out[DV_F20]); // R7
    exa_cur  = pick4(st_ff.exa_sel, src_tick.xtal, dv_out[DV_HSB],
                     src_tick.slow, dv_out[DV_F20]); // R12
    exb_cur  = pick4(st_ff.exb_sel, src_tick.xtal, dv_out[DV_HSB],
                     src_tick.slow, dv_out[DV_F20]); // R12
  end

  // core divider held at two or more while the undivided pll feeds the root
  assign cpu_ratio = ((st_ff.sys_sel == ROOT_PLL) && (i_div_cfg.pll <= RATIO_ONE) &&
                      (i_div_cfg.cpu < CORE_MIN_DIV)) ? CORE_MIN_DIV : i_div_cfg.cpu; // R3

  // ==========================================================
  // divider inputs and ratios
  always_comb begin
    dv_in = '0;
    dv_in[DV_F20]  = src_tick.fast;   // R8
    dv_in[DV_PLL]  = src_tick.pll;    // R3
    dv_in[DV_CPU]  = root_cur;        // R4
    dv_in[DV_SBUS] = root_cur;        // R5
    dv_in[DV_FBUS] = root_cur;        // R5
    dv_in[DV_UHSB] = root_cur;        // R6
    dv_in[DV_HSB]  = root_cur;        // R6
    dv_in[DV_LSB]  = root_cur;        // R6
    dv_in[DV_PER]  = per_cur;         // R7
    dv_in[DV_EXA]  = exa_cur;         // R12
    dv_in[DV_EXB]  = exb_cur;         // R12
    dv_ratio = '0;
    dv_ratio[DV_F20]  = FAST_LPS_DIV;
    dv_ratio[DV_PLL]  = i_div_cfg.pll;
    dv_ratio[DV_CPU]  = cpu_ratio;
    dv_ratio[DV_SBUS] = i_div_cfg.sbus;
    dv_ratio[DV_FBUS] = i_div_cfg.fbus;
    dv_ratio[DV_UHSB] = i_div_cfg.uhsb;
    dv_ratio[DV_HSB]  = i_div_cfg.hsb;
    dv_ratio[DV_LSB]  = i_div_cfg.lsb;
    dv_ratio[DV_PER]  = i_div_cfg.per;
    dv_ratio[DV_EXA]  = i_div_cfg.exa;
    dv_ratio[DV_EXB]  = i_div_cfg.exb;
  end

  // one divider per derived clock
  for (genvar g = 0; g < DV_N; g++) begin : g_div
    sctr_tick_div u_div (
      .i_system_root_clock (i_system_root_clock),
      .i_sys_rst (i_sys_rst),
      .i_tick    (dv_in[g]),
      .i_ratio   (dv_ratio[g]),
      .o_tick    (dv_out[g])
    );
  end

  assign mon_src = {src_tick.pll, src_tick.slow, src_tick.fast, src_tick.xtal};
  assign win_end = src_tick.hv && (st_ff.win == (MON_WIN - MON_ONE));

  // ==========================================================
  // next state: sync, selectors, registered enables, monitors
  always_comb begin
    nxt_st = st_ff;
    nxt_st.src_s1 = i_src_lvl;
    nxt_st.src_s2 = st_ff.src_s1;
    nxt_st.src_s3 = st_ff.src_s2;
    nxt_st.stb_s1 = i_fast_stable;
    nxt_st.stb_s2 = st_ff.stb_s1;
    // a selection moves only in a cycle where old and new source are idle,
    // so no pulse is cut short or doubled across the switch
    if (!src_tick.fast && !src_tick.slow) begin
      nxt_st.iosc_sel = i_iosc_sel; // R15
    end
    if (!dv_out[DV_PLL] && !iosc_cur) begin
      nxt_st.sys_sel = i_sys_sel; // R15
    end
    if (!per_cur && !pick4(i_per_sel, src_tick.xtal, dv_out[DV_HSB],
                           src_tick.slow, dv_out[DV_F20])) begin
      nxt_st.per_sel = i_per_sel; // R15
    end
    if (!exa_cur && !pick4(i_exa_sel, src_tick.xtal, dv_out[DV_HSB],
                           src_tick.slow, dv_out[DV_F20])) begin
      nxt_st.exa_sel = i_exa_sel; // R15
    end
    if (!exb_cur && !pick4(i_exb_sel, src_tick.xtal, dv_out[DV_HSB],
                           src_tick.slow, dv_out[DV_F20])) begin
      nxt_st.exb_sel = i_exb_sel; // R15
    end
    nxt_st.sys_tick  = root_cur;
    nxt_st.iosc_tick = iosc_cur;
    nxt_st.lps_tick  = st_ff.stb_s2 ? dv_out[DV_F20] : iosc_cur; // R8
    nxt_st.ecm_tick  = dv_out[DV_F20]; // R9
    nxt_st.mon_tick  = mon_src;        // R10
    nxt_st.smp_tick  = src_tick.hv;    // R10
    nxt_st.reg_tick  = dv_out[DV_LSB]; // R10
    nxt_st.xtal_err  = i_crystal_freq_select[XTAL_BAD_BIT]; // R14
    // sampling window counted in high-voltage oscillator pulses
    if (src_tick.hv) begin
      nxt_st.win = win_end ? '0 : (st_ff.win + MON_ONE);
    end
    for (int m = 0; m < MON_N; m++) begin
      if (!i_mon_en[m]) begin
        nxt_st.mon_cnt[m] = '0;
        nxt_st.anom[m]    = 1'b0;
        nxt_st.armed[m]   = 1'b0;
      end else if (win_end) begin
        // the first window after enable is partial, so it only arms the check
        if (st_ff.armed[m] &&
            ((st_ff.mon_cnt[m] < MON_LO[m]) || (st_ff.mon_cnt[m] > MON_HI[m]))) begin
          nxt_st.anom[m] = 1'b1; // R11
        end
        nxt_st.armed[m]   = 1'b1;
        nxt_st.mon_cnt[m] = '0;
      end else if (mon_src[m] && (st_ff.mon_cnt[m] != MON_MAX)) begin
        nxt_st.mon_cnt[m] = st_ff.mon_cnt[m] + MON_ONE; // R11
      end
    end
  end

  // boots from the slow internal oscillator with every selector at code zero
  always_ff @(posedge i_system_root_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign o_sys_tick     = st_ff.sys_tick;
  assign o_iosc_tick    = st_ff.iosc_tick;
  assign o_pll_tick     = dv_out[DV_PLL];
  assign o_bus.cpu      = dv_out[DV_CPU];
  assign o_bus.sbus     = dv_out[DV_SBUS];
  assign o_bus.fbus     = dv_out[DV_FBUS];
  assign o_bus.uhsb     = dv_out[DV_UHSB];
  assign o_bus.hsb      = dv_out[DV_HSB];
  assign o_bus.lsb      = dv_out[DV_LSB];
  assign o_per_tick     = dv_out[DV_PER];
  assign o_lps_tick     = st_ff.lps_tick;
  assign o_ecm_tick     = st_ff.ecm_tick;
  assign o_exa_tick     = dv_out[DV_EXA];
  assign o_exb_tick     = dv_out[DV_EXB];
  assign o_mon_tick     = st_ff.mon_tick;
  assign o_mon_smp_tick = st_ff.smp_tick;
  assign o_mon_reg_tick = st_ff.reg_tick;
  assign o_mon_anom     = st_ff.anom;
  assign o_xtal_cfg_err = st_ff.xtal_err;

  // ==========================================================
  // checks
  logic [7:0] f20_gap_ff;
  logic       f20_seen_ff;

  // helper: fast pulses between two divided pulses
  always_ff @(posedge i_system_root_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      f20_gap_ff  <= '0;
      f20_seen_ff <= 1'b0;
    end else if (dv_out[DV_F20]) begin
      f20_gap_ff  <= src_tick.fast ? GAP_ONE : '0;
      f20_seen_ff <= 1'b1;
    end else if (src_tick.fast) begin
      f20_gap_ff  <= f20_gap_ff + GAP_ONE;
    end
  end

  default clocking cb @(posedge i_system_root_clock); endclocking
  default disable iff (i_sys_rst);

  fast_div_twenty_a: assert property ( // R8
    (dv_out[DV_F20] && f20_seen_ff) |-> (f20_gap_ff == FAST_LPS_DIV[7:0]))
    else $error("fast divided clock is not one in twenty");
  lps_source_a: assert property ( // R8
    ##1 o_lps_tick == ($past(st_ff.stb_s2) ? $past(dv_out[DV_F20]) : $past(iosc_cur)))
    else $error("sampler clock from wrong source");
  ecm_count_a: assert property ( // R9
    dv_out[DV_F20] |=> o_ecm_tick)
    else $error("count clock missed a divided pulse");
  root_mux_a: assert property ( // R2
    o_sys_tick |-> ($past(st_ff.sys_sel) == ROOT_PLL ? $past(dv_out[DV_PLL])
                                                    : $past(iosc_cur)))
    else $error("root clock pulse from unselected source");
  sel_glitch_a: assert property ( // R15
    $changed(st_ff.sys_sel) |-> $past(!dv_out[DV_PLL] && !iosc_cur))
    else $error("root selector moved while a source pulsed");
  core_cap_a: assert property ( // R3
    (st_ff.sys_sel == ROOT_PLL && i_div_cfg.pll <= RATIO_ONE)
      |-> (dv_ratio[DV_CPU] >= CORE_MIN_DIV))
    else $error("core clock at full vco rate");
  ext_source_a: assert property ( // R12
    $past(i_div_cfg.exa <= RATIO_ONE) |-> (o_exa_tick == $past(exa_cur)))
    else $error("external output fed by wrong source");
  anom_window_a: assert property ( // R11
    $rose(o_mon_anom[1]) |-> $past(win_end && i_mon_en[1] && st_ff.armed[1]))
    else $error("anomaly flagged outside window end");
  xtal_code_a: assert property ( // R14
    ##1 o_xtal_cfg_err == $past(i_crystal_freq_select[XTAL_BAD_BIT]))
    else $error("prohibited crystal code not flagged");

endmodule
`default_nettype wire

/* sim/sctr_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// free running oscillator sources feeding the clock tree
module sctr_osc_model
  import sctr_pkg::*;
(
  // clock
  input  wire logic i_system_root_clock,
  // raw source levels
  output sctr_src_t o_src_lvl
);
  logic [4:0] n_ff = 5'h00;

  // oscillators never stop, so reset does not touch the counter
  always_ff @(negedge i_system_root_clock) begin
    n_ff <= n_ff + 5'h01;
  end

  // periods in system cycles: pll 4, fast 8, hv 8, crystal 16, slow 32
  assign o_src_lvl.pll  = n_ff[1];
  assign o_src_lvl.fast = n_ff[2];
  assign o_src_lvl.hv   = n_ff[2];
  assign o_src_lvl.xtal = n_ff[3];
  assign o_src_lvl.slow = n_ff[4];
endmodule
`default_nettype wire

/* sim/tb_sctr_clock_tree.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ==========================================================
// bench top
module tb_sctr_clock_tree;
  import sctr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sctr_src_t src;
  logic stable = 1'b1;
  sctr_root_t sys_sel = ROOT_IOSC;
  sctr_iosc_t iosc_sel = IOSC_FAST;
  sctr_sel4_t per_sel = SEL_XTAL;
  sctr_sel4_t exa_sel = SEL_XTAL;
  sctr_sel4_t exb_sel = SEL_XTAL;
  sctr_div_cfg_t cfg = {10{RATIO_ONE}};
  logic [2:0] code = 3'h0;
  logic [MON_N-1:0] mon_en = 4'h0;
  logic o_sys, o_iosc, o_pll, o_per, o_lps, o_ecm, o_exa, o_exb, o_smp, o_reg, o_xerr;
  sctr_bus_tick_t o_bus;
  logic [MON_N-1:0] o_mon, o_anom;
  logic [19:0] t;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  assign t = {o_mon, o_bus, o_reg, o_smp, o_exb, o_exa, o_ecm, o_lps, o_per, o_pll, o_iosc, o_sys};

  // clock
  initial begin
    forever #5 clk = ~clk;
  end

  sctr_osc_model osc_u (.i_system_root_clock(clk), .o_src_lvl(src));

  // fast monitor upper bound kept low so its 15 counts per window are out of range
  sctr_clock_tree #(.MON_HI({16'h0100, 16'h0100, 16'h000C, 16'h0100})) dut_u (
    .i_system_root_clock(clk), .i_sys_rst(rst), .i_src_lvl(src), .i_fast_stable(stable),
    .i_sys_sel(sys_sel), .i_iosc_sel(iosc_sel), .i_per_sel(per_sel),
    .i_exa_sel(exa_sel), .i_exb_sel(exb_sel), .i_div_cfg(cfg),
    .i_crystal_freq_select(code), .i_mon_en(mon_en),
    .o_sys_tick(o_sys), .o_iosc_tick(o_iosc), .o_pll_tick(o_pll), .o_bus(o_bus),
    .o_per_tick(o_per), .o_lps_tick(o_lps), .o_ecm_tick(o_ecm),
    .o_exa_tick(o_exa), .o_exb_tick(o_exb), .o_mon_tick(o_mon),
    .o_mon_smp_tick(o_smp), .o_mon_reg_tick(o_reg), .o_mon_anom(o_anom),
    .o_xtal_cfg_err(o_xerr));

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard, the full sequence needs well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end

  // cycles until the next pulse on one tick, read at the falling edge
  task automatic wait_tick(input int idx, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (t[idx] !== 1'b1 && n < 3000);
  endtask

  // spacing of two pulses after the settings had time to settle
  task automatic gap(input int idx, input int e, input string nm);
    int n;
    wait_tick(idx, n);
    wait_tick(idx, n);
    wait_tick(idx, n);
    `CHK(nm, e, n)
  endtask

  task automatic t_reset();
    @(negedge clk);
    `CHK("ticks in reset", 20'h00000, t)
    `CHK("xtal err in reset", 1'b0, o_xerr)
  endtask

  task automatic t_root();
    sys_sel = ROOT_PLL;
    gap(0, 4, "root pll");
    sys_sel = ROOT_IOSC;
    gap(0, 8, "root fast");
    gap(1, 8, "iosc fast");
    iosc_sel = IOSC_SLOW;
    gap(0, 32, "root slow");
    gap(1, 32, "iosc slow");
  endtask

  task automatic t_bus();
    sys_sel = ROOT_PLL;
    cfg.cpu = 10'h002;
    cfg.sbus = 10'h003;
    cfg.fbus = 10'h004;
    cfg.uhsb = 10'h005;
    cfg.hsb = 10'h006;
    cfg.lsb = 10'h007;
    for (int i = 0; i < 6; i++) begin
      gap(15 - i, (i + 2) * 4, "bus clock");
    end
    cfg.pll = 10'h002;
    gap(2, 8, "pll out");
    cfg.pll = RATIO_ONE;
    cfg.cpu = RATIO_ONE;
    gap(15, 8, "core cap");
  endtask

  // each selector code against the period of the source it names
  task automatic t_sel();
    int e [4] = '{16, 24, 32, 160};
    cfg.per = 10'h002;
    cfg.exb = 10'h003;
    for (int s = 0; s < 4; s++) begin
      per_sel = sctr_sel4_t'(s);
      exa_sel = sctr_sel4_t'(s);
      exb_sel = sctr_sel4_t'(s);
      gap(3, 2 * e[s], "periph sel");
      gap(6, e[s], "ext a sel");
      gap(7, 3 * e[s], "ext b sel");
    end
  endtask

  task automatic t_lps();
    gap(4, 160, "lps stable");
    gap(5, 160, "ecm count");
    stable = 1'b0;
    gap(4, 32, "lps unstable");
    stable = 1'b1;
  endtask

  task automatic t_mon();
    gap(16, 16, "mon xtal");
    gap(17, 8, "mon fast");
    gap(18, 32, "mon slow");
    gap(19, 4, "mon pll");
    gap(8, 8, "mon sample");
    gap(9, 28, "mon reg");
    mon_en = 4'hF;
    repeat (400) @(negedge clk);
    `CHK("anomaly", 4'h2, o_anom)
    mon_en = 4'h0;
    repeat (2) @(negedge clk);
    `CHK("anomaly off", 4'h0, o_anom)
  endtask

  task automatic t_xtal();
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      repeat (2) @(negedge clk);
      `CHK("xtal code err", code[2], o_xerr)
    end
  endtask

  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_root();
    t_bus();
    t_sel();
    t_lps();
    t_mon();
    t_xtal();
    summarize();
  end
endmodule
`default_nettype wire
